// ### swd_top.sv
/*
  System watchdog timer: 16-bit counter, prescaled, reloaded on service,
  disable only before end of init, overflow drives an internal reset and
  pulls the reset output pin low. Assumes commands are one-cycle pulses.
*/
// Operation
// - watchdog enabled and counting right after every reset.
// - disable request honoured only before end of initialization.
// - overflow raises internal reset and drives reset output pin low.
// - 16-bit counter advancing at core clock divided by 2/4/128/256.
// - each service while enabled loads counter high byte from reload value; disabled or tripped, the counter holds.
// - reset defaults give full 16-bit count at divide by two.
// - end of init releases reset output pin and closes disable window.
`default_nettype none
module swd_top
  import swd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // software requests
  input wire swd_cmd_t cmd,
  input wire swd_cfg_t cfg,
  // status
  output logic [15:0] count,
  output logic enabled,
  output logic init_done,
  output logic [7:0] watchdog_reload_value,
  // resets
  output logic wdt_reset_req,
  output logic reset_output_pin_n
);
  swd_state_t state;
  swd_state_t next_state;
  swd_div_t div;
  logic tick;
  logic [3:0] hold_cnt;
  logic overflow;

  // prescaler restarts on service, so a reload always gets its full interval
  swd_prescaler u_pre
  (
    .core_clk(core_clk),
    .rst(rst),
    .clear(cmd.service),
    .div(div),
    .tick(tick)
  );

  // overflow when the counter wraps on a tick while in init or run
  assign overflow = (state == SWD_ST_INIT || state == SWD_ST_RUN) &&
                    tick && (count == SWD_CNT_MAX) && !cmd.service;

  // state: disable accepted only before end of init
  always_comb
  begin
    next_state = state;
    case (state)
      SWD_ST_INIT:
      begin
        if (overflow)
          next_state = SWD_ST_TRIP;
        else if (cmd.disable_req)
          next_state = SWD_ST_OFF;
        else if (cmd.end_of_init)
          next_state = SWD_ST_RUN;
      end
      SWD_ST_RUN:
      begin
        if (overflow)
          next_state = SWD_ST_TRIP;
      end
      SWD_ST_OFF:
        next_state = SWD_ST_OFF;
      SWD_ST_TRIP:
      begin
        // trip holds until the system reset it requested arrives
        next_state = SWD_ST_TRIP;
      end
      default: next_state = SWD_ST_INIT;
    endcase
  end

  // starts supervising straight out of reset, no software needed
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state <= SWD_ST_INIT;
    else
      state <= next_state;
  end

  // end of init latch, kept even if watchdog was disabled
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      init_done <= 1'b0;
    else if (cmd.end_of_init)
      init_done <= 1'b1;
  end

  // configuration; reset values give a full 16-bit count at divide by two
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div <= SWD_DIV2;
      watchdog_reload_value <= SWD_REL_RST;
    end
    else if (cmd.load_cfg)
    begin
      div <= cfg.div;
      watchdog_reload_value <= cfg.reload;
    end
  end

  // counter: service reloads high byte and clears low byte
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count <= SWD_CNT_RST;
    else if (state == SWD_ST_OFF || state == SWD_ST_TRIP)
      count <= count;
    else if (cmd.service)
      count <= {watchdog_reload_value, 8'h00};
    else if (tick)
      count <= count + 16'h0001;
  end

  // from the state register, so it drops on the same edge as a trip
  assign enabled = (state == SWD_ST_INIT || state == SWD_ST_RUN);

  // internal reset request pulse, a few cycles so the core catches it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hold_cnt <= 4'h0;
    else if (overflow)
      hold_cnt <= SWD_RST_HOLD;
    else if (hold_cnt != 4'h0)
      hold_cnt <= hold_cnt - 4'h1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wdt_reset_req <= 1'b0;
    else
      wdt_reset_req <= overflow || (hold_cnt > 4'h1);
  end

  // pin low through reset and until end of init; low again on trip
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reset_output_pin_n <= 1'b0;
    else if (overflow || state == SWD_ST_TRIP)
      reset_output_pin_n <= 1'b0;
    else if (cmd.end_of_init)
      reset_output_pin_n <= 1'b1;
  end

  // checks; each guards the rule tagged on its label line
  chk_overflow_trips: assert property (
    @(posedge core_clk) disable iff (rst)
    overflow |=> !reset_output_pin_n && wdt_reset_req && !enabled)
    else $error("overflow did not raise reset");
  chk_service_reload: assert property (
    @(posedge core_clk) disable iff (rst)
    cmd.service && enabled
    |=> count == {$past(watchdog_reload_value), 8'h00})
    else $error("service did not reload counter");
  // a real overflow after end of init is the one legal way out of run
  chk_disable_late: assert property (
    @(posedge core_clk) disable iff (rst)
    init_done && enabled && !overflow |=> enabled)
    else $error("watchdog stopped after end of init");
  chk_disable_early: assert property (
    @(posedge core_clk) disable iff (rst)
    state == SWD_ST_INIT && cmd.disable_req && !overflow |=> !enabled)
    else $error("early disable ignored");
  chk_count_tick: assert property (
    @(posedge core_clk) disable iff (rst)
    enabled && tick && !cmd.service && count != SWD_CNT_MAX
    |=> count == $past(count) + 16'h0001)
    else $error("counter missed a tick");
  // service or a new divider restarts the pattern, so both are excluded
  chk_div2_rate: assert property (
    @(posedge core_clk) disable iff (rst)
    div == SWD_DIV2 && tick ##1 div == SWD_DIV2 && !cmd.service
    ##1 div == SWD_DIV2 && !cmd.service |-> tick && !$past(tick))
    else $error("divide by two rate wrong");
  chk_end_of_init_instruction_pin: assert property (
    @(posedge core_clk) disable iff (rst)
    cmd.end_of_init && !overflow && state != SWD_ST_TRIP
    |=> reset_output_pin_n && init_done)
    else $error("end of init not signalled");
  chk_start_enabled: assert property (
    @(posedge core_clk) disable iff (rst)
    $fell(rst) |-> enabled && !init_done && !reset_output_pin_n)
    else $error("not supervising after reset");
  chk_reset_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    overflow |=> wdt_reset_req [*8] ##1 !wdt_reset_req)
    else $error("reset pulse length wrong");
  // a stopped or tripped watchdog must not drift toward another overflow
  chk_off_frozen: assert property (
    @(posedge core_clk) disable iff (rst)
    !enabled |=> $stable(count))
    else $error("counter moved while stopped");
  chk_pin_until_init: assert property (
    @(posedge core_clk) disable iff (rst)
    !init_done && !cmd.end_of_init |=> !reset_output_pin_n)
    else $error("reset output released before end of init");
  chk_trip_latched: assert property (
    @(posedge core_clk) disable iff (rst)
    state == SWD_ST_TRIP |=> state == SWD_ST_TRIP && !reset_output_pin_n)
    else $error("trip released without reset");
endmodule
`default_nettype wire

// ### swd_pkg.sv
/*
  Shared constants and types for the system watchdog timer.
  Assumes a single core clock domain and an asynchronous active-high reset.
*/
`default_nettype none
package swd_pkg;
  localparam int SWD_CNT_W = 16;
  localparam int SWD_REL_W = 8;
  localparam int SWD_PRE_W = 8;
  // counter and reload after reset: full 16-bit count at divide-by-two
  localparam logic [15:0] SWD_CNT_RST = 16'h0000;
  localparam logic [7:0] SWD_REL_RST = 8'h00;
  localparam logic [15:0] SWD_CNT_MAX = 16'hFFFF;
  // prescaler dividers, encoded as terminal counts of the divider
  localparam logic [7:0] SWD_DIV2_TC = 8'h01;
  localparam logic [7:0] SWD_DIV4_TC = 8'h03;
  localparam logic [7:0] SWD_DIV128_TC = 8'h7F;
  localparam logic [7:0] SWD_DIV256_TC = 8'hFF;
  // cycles the internal reset pulse is held after an overflow
  localparam logic [3:0] SWD_RST_HOLD = 4'h8;

  typedef enum logic [1:0]
  {
    SWD_DIV2,
    SWD_DIV4,
    SWD_DIV128,
    SWD_DIV256
  } swd_div_t;

  // one-cycle software requests from the core
  typedef struct packed
  {
    logic service;
    logic disable_req;
    logic end_of_init;
    logic load_cfg;
  } swd_cmd_t;

  // configuration written along with load_cfg
  typedef struct packed
  {
    swd_div_t div;
    logic [7:0] reload;
  } swd_cfg_t;

  typedef enum logic [1:0]
  {
    SWD_ST_INIT,
    SWD_ST_RUN,
    SWD_ST_OFF,
    SWD_ST_TRIP
  } swd_state_t;
endpackage
`default_nettype wire

// ### swd_prescaler.sv
/*
  Clock prescaler for the watchdog: emits one tick every 2, 4, 128 or 256
  core cycles. Assumes the caller clears it on service to restart timing.
*/
`default_nettype none
module swd_prescaler
  import swd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire swd_div_t div,
  // tick out
  output logic tick
);
  logic [7:0] pre_cnt;

  // terminal count for the selected divider
  function automatic logic [7:0] swd_tc(input swd_div_t d);
    case (d)
      SWD_DIV2: swd_tc = SWD_DIV2_TC;
      SWD_DIV4: swd_tc = SWD_DIV4_TC;
      SWD_DIV128: swd_tc = SWD_DIV128_TC;
      default: swd_tc = SWD_DIV256_TC;
    endcase
  endfunction

  assign tick = (pre_cnt == swd_tc(div)) && !clear;

  // free divider; >= guards a divider shrunk mid-count
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pre_cnt <= 8'h00;
    else if (clear || pre_cnt >= swd_tc(div))
      pre_cnt <= 8'h00;
    else
      pre_cnt <= pre_cnt + 8'h01;
  end
endmodule
`default_nettype wire

// ### swd_top_tb_top.sv
/*
  Self-checking bench for the system watchdog timer top.
  Assumes swd_pkg and the design modules are compiled before it.
*/
`default_nettype none
module swd_top_tb_top
  import swd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam swd_cmd_t C_SRV = 4'h8;
  localparam swd_cmd_t C_DIS = 4'h4;
  localparam swd_cmd_t C_EOI = 4'h2;
  localparam swd_cmd_t C_CFG = 4'h1;
  logic core_clk;
  logic rst;
  swd_cmd_t cmd;
  swd_cfg_t cfg;
  logic [15:0] count;
  logic enabled;
  logic init_done;
  logic [7:0] reload_q;
  logic wdt_reset_req;
  logic reset_output_pin_n;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  swd_top dut (.core_clk(core_clk), .rst(rst), .cmd(cmd), .cfg(cfg),
    .count(count), .enabled(enabled), .init_done(init_done),
    .watchdog_reload_value(reload_q), .wdt_reset_req(wdt_reset_req),
    .reset_output_pin_n(reset_output_pin_n));

  // 25 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // hang guard: whole run needs well under 5000 cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // let edge updates land before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    cmd <= '0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    settle(1);
  endtask

  // one-cycle command pulse, sampled on the edge that drops it
  task automatic send(input swd_cmd_t c, input swd_cfg_t f);
    @(posedge core_clk);
    cmd <= c;
    cfg <= f;
    @(posedge core_clk);
    cmd <= '0;
    #1;
  endtask

  // cycles between two successive counter steps
  task automatic tick_period(input logic [15:0] exp_n);
    logic [15:0] c0;
    int n;
    for (int k = 0; k < 2; k++)
    begin
      c0 = count;
      n = 0;
      while (count === c0 && n < 600)
      begin
        settle(1);
        n++;
      end
    end
    chk(16'(n), exp_n);
  endtask

  task automatic t_reset();
    do_reset();
    chk(16'(enabled), 16'h0001);
    chk(16'(init_done), 16'h0000);
    chk(16'(reset_output_pin_n), 16'h0000);
    chk(16'(reload_q), 16'h0000);
    tick_period(16'h0002);
    $display("test reset done");
  endtask

  task automatic t_prescale();
    logic [15:0] exp_n [4] = '{16'h0002, 16'h0004, 16'h0080, 16'h0100};
    for (int d = 0; d < 4; d++)
    begin
      send(C_CFG, '{div: swd_div_t'(d), reload: 8'h12});
      chk(16'(reload_q), 16'h0012);
      send(C_SRV, cfg);
      chk(count, 16'h1200);
      tick_period(exp_n[d]);
    end
    $display("test prescale done");
  endtask

  task automatic t_disable();
    logic [15:0] c0;
    do_reset();
    send(C_DIS, cfg);
    chk(16'(enabled), 16'h0000);
    c0 = count;
    settle(10);
    chk(count, c0);
    do_reset();
    send(C_EOI, cfg);
    chk(16'(init_done), 16'h0001);
    chk(16'(reset_output_pin_n), 16'h0001);
    send(C_DIS, cfg);
    chk(16'(enabled), 16'h0001);
    tick_period(16'h0002);
    $display("test disable done");
  endtask

  // missed service trips; prompt service does not
  task automatic t_overflow();
    int n;
    send(C_CFG, '{div: SWD_DIV2, reload: 8'hFF});
    send(C_SRV, cfg);
    settle(400);
    send(C_SRV, cfg);
    chk(count, 16'hFF00);
    chk(16'(wdt_reset_req), 16'h0000);
    n = 0;
    while (wdt_reset_req !== 1'b1 && n < 600)
    begin
      settle(1);
      n++;
    end
    // 256 ticks at divide by two from the reload to the overflow
    chk(16'(n), 16'h0200);
    chk(16'(reset_output_pin_n), 16'h0000);
    chk(16'(enabled), 16'h0000);
    n = 0;
    while (wdt_reset_req === 1'b1 && n < 20)
    begin
      n++;
      settle(1);
    end
    chk(16'(n), 16'(SWD_RST_HOLD));
    chk(16'(reset_output_pin_n), 16'h0000);
    do_reset();
    chk(16'(enabled), 16'h0001);
    $display("test overflow done");
  endtask

  initial
  begin
    rst = 1'b1;
    cmd = '0;
    cfg = '0;
    t_reset();
    t_prescale();
    t_disable();
    t_overflow();
    close_out();
  end
endmodule
`default_nettype wire
